// >>> hdl/pcm_pkg.sv
/*
 * Shared constants and state types of the packet channel memory.
 * Assumes one instance per channel and a controller obeying packet timing.
 */
package pcm_pkg;
    localparam int BANKS     = 2;
    localparam int ROWS      = 512;
    localparam int COLS      = 256;
    localparam int BANK_W    = 1;
    localparam int ROW_W     = 9;
    localparam int COL_W     = 8;
    localparam int ADDR_W    = BANK_W + ROW_W + COL_W;
    localparam int MEM_WORDS = BANKS * ROWS * COLS;
    localparam int BEATS     = 8;
    localparam int WIRES     = 9;
    // Command wire bit positions within one packet interval
    localparam int START_POS = 0;
    localparam int STRB_POS  = 1;
    localparam int TERM_POS  = 3;
    // Request fields, bit n of beat b is request bit 9*b+n
    localparam int REQ_WR_POS   = 0;
    localparam int REQ_ACT_POS  = 1;
    localparam int REQ_REG_POS  = 2;
    localparam int REQ_COL_LSB  = 3;
    localparam int REQ_ROW_LSB  = 11;
    localparam int REQ_BANK_POS = 20;
    localparam int REQ_DEV_LSB  = 21;
    localparam int DEV_W        = 8;
    localparam logic [DEV_W-1:0] DEV_ADDR    = 8'h00;
    localparam logic [2:0]       PH_LAST     = 3'h7;
    localparam logic [8:0]       WIRE_IDLE_N = 9'h1ff;

    typedef logic [BEATS-1:0][WIRES-1:0] pcm_word_t;

    typedef struct packed {
        logic              v;
        logic              wr;
        logic              strobed;
        logic [BANK_W-1:0] bank;
        logic [COL_W-1:0]  col;
    } pcm_slot_t;

    typedef struct packed {
        logic                         locked;
        logic [2:0]                   ph;
        logic [6:0]                   cmd_sh;
        logic [6:0]                   col_sh;
        logic [6:0][WIRES-1:0]        dat_sh;
        logic [COL_W-1:0]             col_q1;
        logic [COL_W-1:0]             col_q2;
        pcm_slot_t                    cur;
        pcm_slot_t                    nxt;
        logic                         rd_first;
        logic                         rd_act;
        logic                         rd_last;
        logic                         wr_first;
        logic                         wr_act;
        pcm_word_t                    out_buf;
        logic [WIRES-1:0]             data_out_n_r;
        logic                         data_oe_n_r;
        logic                         done_tgl;
        logic [BANKS-1:0][ROW_W-1:0]  open_row;
    } pcm_link_t;

    typedef struct packed {
        logic [2:0]  dsy;
        logic        dstable;
        logic [2:0]  lsy;
        logic        link_up_r;
        logic        xact_done_r;
        logic [15:0] xact_count_r;
    } pcm_sys_t;
endpackage

// >>> hdl/pcm_channel_memory.sv
/*
 * Device end of the packet channel: request decode, row activation,
 * strobe/terminate framed column reads and writes, interleaving.
 * Assumes receive_clock is the bit clock (one bit per rising edge) and that
 * the transmit clock is the same source; mclk side only reports status.
 */
`timescale 1ns/1ps
module pcm_channel_memory (
    input  wire logic       mclk,
    input  wire logic       rst_n,
    input  wire logic       receive_clock,
    input  wire logic [8:0] channel_data_in_n,
    output logic [8:0]      channel_data_out_n,
    output logic            channel_data_oe_n,
    input  wire logic       command_wire_n,
    input  wire logic       column_address_wire_n,
    output logic            link_up,
    output logic            xact_done,
    output logic [15:0]     xact_count
);
    pcm_pkg::pcm_link_t               l_r;
    pcm_pkg::pcm_link_t               l_nxt;
    pcm_pkg::pcm_sys_t                s_r;
    pcm_pkg::pcm_sys_t                s_nxt;
    pcm_pkg::pcm_word_t               mem [pcm_pkg::MEM_WORDS];
    logic [2:0]                       lrst_q;
    logic                             lrst_n;
    logic                             tick;
    logic [7:0]                       cmd_pkt;
    logic [7:0]                       col_pkt;
    pcm_pkg::pcm_word_t               dat_word;
    logic [71:0]                      req_bits;
    logic                             req_hit;
    logic                             req_act;
    logic [pcm_pkg::BANK_W-1:0]       req_bank;
    logic [pcm_pkg::ROW_W-1:0]        req_row;
    logic [pcm_pkg::COL_W-1:0]        req_col;
    logic                             strb_ev;
    logic                             term_ev;
    logic                             rd_go;
    logic                             wr_go;
    logic                             mem_we;
    logic [pcm_pkg::ADDR_W-1:0]       mem_waddr;

    function automatic logic [pcm_pkg::ADDR_W-1:0] pcm_addr(
        input logic [pcm_pkg::BANK_W-1:0] bank,
        input logic [pcm_pkg::ROW_W-1:0]  row,
        input logic [pcm_pkg::COL_W-1:0]  col
    );
        return {bank, row, col};
    endfunction

    // Link reset: asserted while either late stage is low
    always_ff @(posedge receive_clock) begin
        lrst_q <= {lrst_q[1:0], rst_n};
    end
    assign lrst_n = lrst_q[1] && lrst_q[2];

    assign tick     = l_r.locked && (l_r.ph == pcm_pkg::PH_LAST);
    assign cmd_pkt  = {~command_wire_n, l_r.cmd_sh};
    assign col_pkt  = {~column_address_wire_n, l_r.col_sh};
    assign dat_word = {~channel_data_in_n, l_r.dat_sh};
    assign req_bits = dat_word;
    assign req_act  = req_bits[pcm_pkg::REQ_ACT_POS];
    assign req_bank = req_bits[pcm_pkg::REQ_BANK_POS];
    assign req_row  = req_bits[pcm_pkg::REQ_ROW_LSB +: pcm_pkg::ROW_W];
    assign req_col  = req_bits[pcm_pkg::REQ_COL_LSB +: pcm_pkg::COL_W];
    // Register-space requests are not served by this memory path
    assign req_hit  = tick && cmd_pkt[pcm_pkg::START_POS]
        && !req_bits[pcm_pkg::REQ_REG_POS]
        && (req_bits[pcm_pkg::REQ_DEV_LSB +: pcm_pkg::DEV_W]
            == pcm_pkg::DEV_ADDR);
    // A marker is only seen in an interval without a start bit
    assign strb_ev  = tick && !cmd_pkt[pcm_pkg::START_POS]
        && cmd_pkt[pcm_pkg::STRB_POS] && l_r.cur.v && !l_r.cur.strobed;
    assign term_ev  = tick && !cmd_pkt[pcm_pkg::START_POS]
        && cmd_pkt[pcm_pkg::TERM_POS];
    assign rd_go    = strb_ev && !l_r.cur.wr;
    assign wr_go    = strb_ev && l_r.cur.wr;
    assign mem_we   = tick && (l_r.wr_first || l_r.wr_act);
    assign mem_waddr = pcm_addr(l_r.cur.bank,
        l_r.open_row[l_r.cur.bank],
        l_r.wr_first ? l_r.cur.col : l_r.col_q2);

    always_comb begin
        logic [pcm_pkg::COL_W-1:0] rcol;
        logic                      retire;
        pcm_pkg::pcm_slot_t        slot;
        rcol   = '0;
        retire = 1'b0;
        slot   = '0;
        l_nxt  = l_r;
        if (!lrst_n) begin
            l_nxt              = '0;
            l_nxt.data_out_n_r = pcm_pkg::WIRE_IDLE_N;
            l_nxt.data_oe_n_r  = 1'b1;
        end else if (!l_r.locked) begin
            // First start bit fixes the interval phase for good
            if (!command_wire_n) begin
                l_nxt.locked    = 1'b1;
                l_nxt.ph        = 3'h1;
                l_nxt.cmd_sh[0] = 1'b1;
                l_nxt.col_sh[0] = ~column_address_wire_n;
                l_nxt.dat_sh[0] = ~channel_data_in_n;
            end
        end else begin
            l_nxt.ph = l_r.ph + 3'h1;
            if (!tick) begin
                l_nxt.cmd_sh[l_r.ph] = ~command_wire_n;
                l_nxt.col_sh[l_r.ph] = ~column_address_wire_n;
                l_nxt.dat_sh[l_r.ph] = ~channel_data_in_n;
                if (!l_r.data_oe_n_r) begin
                    l_nxt.data_out_n_r = ~l_r.out_buf[l_r.ph + 3'h1];
                end
            end else begin
                l_nxt.col_q1 = col_pkt;
                l_nxt.col_q2 = l_r.col_q1;
                // Load the word for the next interval one tick ahead
                if (l_r.rd_first || l_r.rd_act) begin
                    rcol = l_r.rd_first ? l_r.cur.col : l_r.col_q2;
                    l_nxt.out_buf = mem[pcm_addr(l_r.cur.bank,
                        l_r.open_row[l_r.cur.bank], rcol)];
                    l_nxt.data_out_n_r = ~l_nxt.out_buf[0];
                    l_nxt.data_oe_n_r  = 1'b0;
                    l_nxt.rd_first     = 1'b0;
                    l_nxt.rd_act       = !l_r.rd_last;
                    l_nxt.rd_last      = 1'b0;
                    retire             = l_r.rd_last;
                end else begin
                    l_nxt.data_out_n_r = pcm_pkg::WIRE_IDLE_N;
                    l_nxt.data_oe_n_r  = 1'b1;
                end
                if (mem_we) begin
                    l_nxt.wr_first = 1'b0;
                    l_nxt.wr_act   = !term_ev;
                    retire         = retire || term_ev;
                end
                if (strb_ev) begin
                    l_nxt.cur.strobed = 1'b1;
                    l_nxt.wr_first    = l_r.cur.wr;
                    l_nxt.rd_first    = !l_r.cur.wr;
                    // One-word read: strobe and terminate overlay
                    l_nxt.rd_last     = !l_r.cur.wr && term_ev;
                end else if (term_ev && (l_r.rd_first || l_r.rd_act)
                             && !l_r.rd_last) begin
                    l_nxt.rd_last = 1'b1;
                end
                if (retire) begin
                    l_nxt.cur      = l_r.nxt;
                    l_nxt.nxt      = '0;
                    l_nxt.done_tgl = ~l_r.done_tgl;
                end
                if (req_hit) begin
                    slot.v    = 1'b1;
                    slot.wr   = req_bits[pcm_pkg::REQ_WR_POS];
                    slot.bank = req_bank;
                    slot.col  = req_col;
                    // Row opens now; controller keeps the access gap
                    if (req_act) begin
                        l_nxt.open_row[req_bank] = req_row;
                    end
                    // A request during a data phase waits as next
                    if (!l_nxt.cur.v) begin
                        l_nxt.cur = slot;
                    end else begin
                        l_nxt.nxt = slot;
                    end
                end
            end
        end
    end

    always_ff @(posedge receive_clock) begin
        l_r <= l_nxt;
    end

    // Array holds bank, row and column; one word is eight bytes plus parity
    always_ff @(posedge receive_clock) begin
        if (mem_we) begin
            mem[mem_waddr] <= dat_word;
        end
    end

    always_comb begin
        s_nxt             = s_r;
        s_nxt.xact_done_r = 1'b0;
        if (!rst_n) begin
            s_nxt = '0;
        end else begin
            s_nxt.dsy = {s_r.dsy[1:0], l_r.done_tgl};
            s_nxt.lsy = {s_r.lsy[1:0], l_r.locked};
            if (s_r.dsy[1] == s_r.dsy[2]) begin
                s_nxt.dstable = s_r.dsy[2];
                if (s_r.dsy[2] != s_r.dstable) begin
                    s_nxt.xact_done_r  = 1'b1;
                    s_nxt.xact_count_r = s_r.xact_count_r + 16'h0001;
                end
            end
            if (s_r.lsy[1] == s_r.lsy[2]) begin
                s_nxt.link_up_r = s_r.lsy[2];
            end
        end
    end

    always_ff @(posedge mclk) begin
        s_r <= s_nxt;
    end

    // One link clock serves receive and transmit; a board with a separate
    // transmit clock would need its own output stage here
    assign channel_data_out_n = l_r.data_out_n_r;
    assign channel_data_oe_n  = l_r.data_oe_n_r;
    assign link_up            = s_r.link_up_r;
    assign xact_done          = s_r.xact_done_r;
    assign xact_count         = s_r.xact_count_r;

    default clocking cb @(posedge receive_clock);
    endclocking
    default disable iff (!lrst_n);

    sequence rd_word_seq;
        (!channel_data_oe_n)[*8];
    endsequence
    sequence next_tick_seq;
        (l_r.ph == 3'h0) ##7 tick;
    endsequence
    sequence one_word_seq;
        rd_word_seq ##1 channel_data_oe_n;
    endsequence

    read_strobe_a: assert property (rd_go |-> ##9 rd_word_seq)
        else $error("read word not driven two intervals after strobe");
    write_strobe_a: assert property (wr_go |-> ##8 mem_we)
        else $error("write word not captured one interval after strobe");
    column_pipe_a: assert property (
        tick |-> ##16 (l_r.col_q2 == $past(col_pkt, 16)))
        else $error("column word not delayed by two intervals");
    idle_level_a: assert property (
        channel_data_oe_n |-> channel_data_out_n == pcm_pkg::WIRE_IDLE_N)
        else $error("released data wires not at idle level");
    interval_phase_a: assert property (tick |=> next_tick_seq)
        else $error("packet interval is not eight bit times");
    row_open_a: assert property (req_hit && req_act
        |=> l_r.open_row[$past(req_bank)] == $past(req_row))
        else $error("activating request did not open its row");
    read_term_a: assert property (term_ev && l_r.rd_act
        && !l_r.rd_last && !l_r.nxt.v |-> ##17 channel_data_oe_n)
        else $error("read data not ended after terminate");
    interleave_a: assert property (req_hit && l_r.cur.v
        && !l_r.rd_last && !term_ev |=> l_r.nxt.v)
        else $error("overlapping request was not queued");
    // Data wires only turn around at interval boundaries
    oe_interval_a: assert property (
        l_r.locked && (l_r.ph != 3'h0) |-> $stable(channel_data_oe_n))
        else $error("data enable changed inside an interval");
    write_column_a: assert property (
        mem_we && !l_r.wr_first
        |-> mem_waddr[pcm_pkg::COL_W-1:0] == $past(col_pkt, 16))
        else $error("write word not at column sent two intervals before");
    write_term_a: assert property (
        mem_we && term_ev |=> !l_r.wr_act && !l_r.wr_first)
        else $error("write data phase not ended by terminate");
    one_word_read_a: assert property (
        rd_go && term_ev |-> ##9 one_word_seq)
        else $error("one word read not released after its word");
    // A refused request must leave an idle slot idle
    refused_req_a: assert property (
        tick && cmd_pkt[pcm_pkg::START_POS] && !l_r.cur.v
        && (req_bits[pcm_pkg::REQ_REG_POS]
            || (req_bits[pcm_pkg::REQ_DEV_LSB +: pcm_pkg::DEV_W]
                != pcm_pkg::DEV_ADDR)) |=> !l_r.cur.v)
        else $error("refused request was taken");
    queue_advance_a: assert property (
        tick && l_r.rd_last && l_r.nxt.v |=> l_r.cur == $past(l_r.nxt))
        else $error("queued request did not follow the finished read");
    link_lock_a: assert property (
        !l_r.locked && !command_wire_n |=> l_r.locked && (l_r.ph == 3'h1))
        else $error("first start bit did not frame the intervals");
endmodule

// >>> testbench/pcm_ctrl_model.sv
/* Controller model: drives request, marker, column and write packets,
   one bit per falling link edge, and collects read words with their interval.
   Assumes the device launches read beats on rising link edges. */
`timescale 1ns/1ps
module pcm_ctrl_model (
    input  wire logic       rclk,
    output logic [8:0]      data_in_n,
    output logic            cmd_n,
    output logic            col_n,
    input  wire logic [8:0] data_out_n,
    input  wire logic       data_oe_n
);
    logic [8:0]         drv_n  = 9'h1ff;
    pcm_pkg::pcm_word_t rd_buf = '0;
    pcm_pkg::pcm_word_t rd_q[$];
    int                 ivl_q[$];
    int                 ivl_cnt = 0;
    int                 beat    = 0;
    // Terminated wires rest high; either end pulls low to assert
    assign data_in_n = drv_n & (data_oe_n ? 9'h1ff : data_out_n);
    initial begin
        cmd_n = 1'b1;
        col_n = 1'b1;
    end
    // A beat launched on a rising edge is taken at the next falling edge
    always @(negedge rclk) begin
        if (!data_oe_n) begin
            if (beat == 0) begin
                ivl_q.push_back(ivl_cnt);
            end
            rd_buf[beat] = ~data_out_n;
            beat = (beat + 1) % 8;
            if (beat == 0) begin
                rd_q.push_back(rd_buf);
            end
        end
    end
    // One packet interval; data wires are released unless drv is set
    task automatic ivl(input logic [7:0] cmd, input logic [7:0] col,
                       input pcm_pkg::pcm_word_t dat, input logic drv);
        ivl_cnt++;
        for (int p = 0; p < 8; p++) begin
            @(negedge rclk);
            cmd_n = ~cmd[p];
            col_n = ~col[p];
            drv_n = drv ? ~dat[p] : 9'h1ff;
        end
    endtask
    function automatic pcm_pkg::pcm_word_t req(input logic wr, act, rg,
        input logic [7:0] dev, input logic bank, input logic [8:0] row,
        input logic [7:0] col);
        return {43'h0, dev, bank, row, col, rg, act, wr};
    endfunction
endmodule

// >>> testbench/packet_channel_memory_protocol_test.sv
/* Self-checking bench: write then read back, single-word read, refused
   requests, interleaved reads, transaction count on the system side.
   Assumes the controller model keeps intervals back to back. */
`timescale 1ns/1ps
module packet_channel_memory_protocol_test;
    localparam logic [7:0] C_REQ = 8'h01 << pcm_pkg::START_POS;
    localparam logic [7:0] C_STB = 8'h01 << pcm_pkg::STRB_POS;
    localparam logic [7:0] C_TRM = 8'h01 << pcm_pkg::TERM_POS;
    localparam logic [7:0] DEV   = pcm_pkg::DEV_ADDR;
    logic               mclk;
    logic               rst_n;
    logic               receive_clock;
    logic [8:0]         din_n;
    logic [8:0]         dout_n;
    logic               oe_n;
    logic               cmd_n;
    logic               col_n;
    logic               link_up;
    logic               xact_done;
    logic [15:0]        xact_count;
    int                 err_total = 0;
    int                 tests_run = 0;
    int                 exp_cnt   = 0;
    int                 done_seen = 0;
    pcm_pkg::pcm_word_t wd [4];
    logic [7:0]         cl [4];
    pcm_channel_memory pcm_channel_memory_inst (
        .mclk                  (mclk),
        .rst_n                 (rst_n),
        .receive_clock         (receive_clock),
        .channel_data_in_n     (din_n),
        .channel_data_out_n    (dout_n),
        .channel_data_oe_n     (oe_n),
        .command_wire_n        (cmd_n),
        .column_address_wire_n (col_n),
        .link_up               (link_up),
        .xact_done             (xact_done),
        .xact_count            (xact_count)
    );
    pcm_ctrl_model pcm_ctrl_model_inst (
        .rclk       (receive_clock),
        .data_in_n  (din_n),
        .cmd_n      (cmd_n),
        .col_n      (col_n),
        .data_out_n (dout_n),
        .data_oe_n  (oe_n)
    );
    initial begin
        mclk = 1'b0;
        forever #20 mclk = ~mclk;
    end
    // Link clock has its own source, so its phase is offset on purpose
    initial begin
        receive_clock = 1'b0;
        #13;
        forever #62.5 receive_clock = ~receive_clock;
    end
    // Sampled away from the edge that launches the pulse
    always @(negedge mclk) begin
        if (xact_done === 1'b1) begin
            done_seen++;
        end
    end
    task automatic chk_val(input logic [31:0] got, exp);
        tests_run++;
        if (got !== exp) begin
            err_total++;
            $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic chk_word(input pcm_pkg::pcm_word_t got, exp);
        tests_run++;
        if (got !== exp) begin
            err_total++;
            $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic tally_and_finish();
        $display("checks %0d mismatches %0d", tests_run, err_total);
        if (err_total == 0 && tests_run > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask
    task automatic rq(input logic wr, act, rg, input logic [7:0] dev, col);
        pcm_ctrl_model_inst.ivl(C_REQ, col, pcm_ctrl_model_inst.req(wr,
            act, rg, dev, 1'b0, 9'h005, col), 1'b1);
    endtask
    task automatic mk(input logic [7:0] cmd, col, input int idx);
        pcm_ctrl_model_inst.ivl(cmd, col, wd[idx & 3], idx >= 0);
    endtask
    task automatic idle(input int n);
        repeat (n) mk(8'h00, 8'h00, -1);
    endtask
    task automatic chk_rd(input int idx, input int iv);
        pcm_pkg::pcm_word_t w;
        int                 g;
        w = 'x;
        g = -1;
        if (pcm_ctrl_model_inst.rd_q.size() > 0) begin
            w = pcm_ctrl_model_inst.rd_q.pop_front();
            g = pcm_ctrl_model_inst.ivl_q.pop_front();
        end
        chk_word(w, wd[idx]);
        chk_val(g, iv);
    endtask
    task automatic fin(input string name);
        idle(2);
        chk_val(pcm_ctrl_model_inst.rd_q.size(), 32'h0);
        chk_val({16'h0, xact_count}, exp_cnt);
        chk_val(done_seen, exp_cnt);
        $display("test %s done", name);
    endtask
    task automatic t_write_read();
        int t0;
        rq(1'b1, 1'b1, 1'b0, DEV, cl[0]);
        idle(1);
        mk(C_STB, cl[1], -1);
        mk(8'h00, cl[2], 0);
        mk(8'h00, cl[3], 1);
        mk(8'h00, 8'h00, 2);
        mk(C_TRM, 8'h00, 3);
        rq(1'b0, 1'b1, 1'b0, DEV, cl[3]);
        t0 = pcm_ctrl_model_inst.ivl_cnt;
        idle(2);
        mk(C_STB, cl[1], -1);
        mk(8'h00, cl[0], -1);
        mk(8'h00, cl[2], -1);
        mk(C_TRM, 8'h00, -1);
        idle(3);
        chk_rd(3, t0 + 5);
        chk_rd(1, t0 + 6);
        chk_rd(0, t0 + 7);
        chk_rd(2, t0 + 8);
        chk_val({31'h0, link_up}, 32'h1);
        exp_cnt += 2;
        fin("write_read");
    endtask
    task automatic t_single();
        int t0;
        rq(1'b0, 1'b0, 1'b0, DEV, cl[1]);
        t0 = pcm_ctrl_model_inst.ivl_cnt;
        idle(2);
        mk(C_STB | C_TRM, 8'h00, -1);
        idle(3);
        chk_rd(1, t0 + 5);
        exp_cnt += 1;
        fin("single");
    endtask
    // Foreign device and register space must leave the data wires alone
    task automatic t_refused();
        for (int k = 0; k < 2; k++) begin
            rq(1'b0, 1'b1, k[0], (k != 0) ? DEV : DEV + 8'h01, cl[1]);
            idle(2);
            mk(C_STB | C_TRM, 8'h00, -1);
            idle(3);
        end
        fin("refused");
    endtask
    task automatic t_interleave();
        int t0;
        rq(1'b0, 1'b1, 1'b0, DEV, cl[0]);
        t0 = pcm_ctrl_model_inst.ivl_cnt;
        idle(2);
        mk(C_STB, cl[1], -1);
        // Second request lands before the first word; its column packet
        // doubles as the current read's third column
        rq(1'b0, 1'b0, 1'b0, DEV, cl[2]);
        mk(C_TRM, 8'h00, -1);
        idle(1);
        mk(C_STB, cl[3], -1);
        mk(C_TRM, 8'h00, -1);
        idle(3);
        chk_rd(0, t0 + 5);
        chk_rd(1, t0 + 6);
        chk_rd(2, t0 + 7);
        chk_rd(2, t0 + 9);
        chk_rd(3, t0 + 10);
        exp_cnt += 2;
        fin("interleave");
    endtask
    initial begin
        #400000;
        err_total++;
        $display("[FAIL] t=%0t got=%h exp=%h", $time, 1'b0, 1'b1);
        tally_and_finish();
    end
    initial begin
        rst_n = 1'b0;
        wd = '{72'h12_3456_789a_bcde_f012, 72'hfe_dcba_9876_5432_10ab,
               72'h00_ff00_ff00_ff00_ff01, 72'ha5_5a5a_a5a5_5a5a_a5c3};
        cl = '{8'h17, 8'h9c, 8'h03, 8'hf0};
        repeat (20) @(negedge mclk);
        chk_val({22'h0, oe_n, dout_n}, {22'h0, 1'b1, 9'h1ff});
        chk_val({31'h0, link_up}, 32'h0);
        rst_n = 1'b1;
        repeat (8) @(negedge receive_clock);
        t_write_read();
        t_single();
        t_refused();
        t_interleave();
        tally_and_finish();
    end
endmodule
